// *** bench/config_word_decode_assertions.sv ***
// ***************************************************************
// Port checker for the configuration word decoder
// ***************************************************************
module config_word_decode_chk #(
  parameter int unsigned FLASH_PAGES = 128
) (
  input wire logic                   core_clk_i,
  input wire logic                   rstn_i,
  input wire logic                   load_ready_o,
  input wire logic                   load_done_o,
  input wire logic [1:0]             rd_idx_i,
  input wire logic [23:0]            rd_data_o,
  input wire logic                   sleep_i,
  input wire logic                   deep_sleep_i,
  input wire logic                   sys_clk_is_low_power_rc_osc_i,
  input wire logic                   wdog_windowed_i,
  input wire cfg_pkg::wdog_cfg_t     wdog_cfg_o,
  input wire cfg_pkg::clock_cfg_t    clock_cfg_o,
  input wire cfg_pkg::protect_cfg_t  protect_cfg_o,
  input wire cfg_pkg::misc_cfg_t     misc_cfg_o,
  input wire logic                   brownout_active_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  // Completion of the load sequence
  sequence done_rise;
    $rose(load_done_o);
  endsequence
  sequence done_steady;
    load_done_o && $past(load_done_o);
  endsequence

  prescale_sel_a : assert property (rd_idx_i == 2'h0 |->
    wdog_cfg_o.prescale_log2 == (rd_data_o[4] ? 4'h7 : 4'h5)) else $error("prescale wrong");
  postscale_sel_a : assert property (rd_idx_i == 2'h0 |->
    wdog_cfg_o.postscale_log2 == rd_data_o[3:0]) else $error("postscale wrong");
  upper_ones_a : assert property (rd_data_o[23:16] == 8'hff)
    else $error("upper byte not ones");
  two_speed_a : assert property (rd_idx_i == 2'h1 |->
    clock_cfg_o.two_speed_en == rd_data_o[15]) else $error("two-speed wrong");
  wdog_mux_off_a : assert property (rd_idx_i == 2'h1 && !rd_data_o[13] |->
    wdog_cfg_o.clk_src == cfg_pkg::WCLK_LOW_POWER_RC) else $error("mux off source wrong");
  wdog_code_ten_a : assert property (rd_idx_i == 2'h1 && rd_data_o[13]
    && rd_data_o[4:3] == 2'h2 |-> wdog_cfg_o.clk_src == ((wdog_windowed_i && !sys_clk_is_low_power_rc_osc_i
    && !sleep_i) ? cfg_pkg::WCLK_FAST_RC_31K : cfg_pkg::WCLK_LOW_POWER_RC)) else $error("code ten");
  bor_active_a : assert property (brownout_active_o
    == (misc_cfg_o.brownout_en && !deep_sleep_i)) else $error("brown-out active wrong");
  window_sel_a : assert property (rd_idx_i == 2'h2 |->
    wdog_cfg_o.window == rd_data_o[10:9]) else $error("window wrong");
  cfg_page_prot_a : assert property (rd_idx_i == 2'h2 && (rd_data_o[15]
    || rd_data_o[6:0] == 7'(FLASH_PAGES - 1)) |-> protect_cfg_o.cfg_page_prot)
    else $error("config page unprotected");
  done_holds_a : assert property (done_rise |=> load_done_o[*8] ##0 !load_ready_o)
    else $error("done dropped");
  decode_stable_a : assert property (done_steady |->
    $stable(clock_cfg_o) && $stable(protect_cfg_o)) else $error("decode changed");
endmodule // config_word_decode_chk

bind config_word_decode config_word_decode_chk #(.FLASH_PAGES(FLASH_PAGES)) i_chk (
  .core_clk_i(core_clk_i), .rstn_i(rstn_i), .load_ready_o(load_ready_o),
  .load_done_o(load_done_o), .rd_idx_i(rd_idx_i), .rd_data_o(rd_data_o),
  .sleep_i(sleep_i), .deep_sleep_i(deep_sleep_i), .sys_clk_is_low_power_rc_osc_i(sys_clk_is_low_power_rc_osc_i),
  .wdog_windowed_i(wdog_windowed_i), .wdog_cfg_o(wdog_cfg_o), .clock_cfg_o(clock_cfg_o),
  .protect_cfg_o(protect_cfg_o), .misc_cfg_o(misc_cfg_o),
  .brownout_active_o(brownout_active_o));

// *** bench/config_word_decode_test.sv ***
`define CHECK(g, e) check_val(64'(g), 64'(e))

module config_word_decode_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned PAGES = 128;
  logic                  core_clk_i, rstn_i, load_valid_i, sleep_i, deep_sleep_i;
  logic                  sys_clk_is_low_power_rc_osc_i, wdog_windowed_i, load_ready_o, load_done_o;
  logic                  brownout_active_o;
  logic [1:0]            load_idx_i, rd_idx_i;
  logic [23:0]           load_data_i, rd_data_o;
  cfg_pkg::wdog_cfg_t    wdog_cfg_o;
  cfg_pkg::clock_cfg_t   clock_cfg_o;
  cfg_pkg::protect_cfg_t protect_cfg_o;
  cfg_pkg::misc_cfg_t    misc_cfg_o;
  int                    n_fail, check_count, cycles;

  config_word_decode #(.FLASH_PAGES(PAGES)) i_config_word_decode (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .load_valid_i(load_valid_i),
    .load_idx_i(load_idx_i), .load_data_i(load_data_i), .load_ready_o(load_ready_o),
    .load_done_o(load_done_o), .rd_idx_i(rd_idx_i), .rd_data_o(rd_data_o),
    .sleep_i(sleep_i), .deep_sleep_i(deep_sleep_i), .sys_clk_is_low_power_rc_osc_i(sys_clk_is_low_power_rc_osc_i),
    .wdog_windowed_i(wdog_windowed_i), .wdog_cfg_o(wdog_cfg_o), .clock_cfg_o(clock_cfg_o),
    .protect_cfg_o(protect_cfg_o), .misc_cfg_o(misc_cfg_o),
    .brownout_active_o(brownout_active_o));

  // ***************************************************************
  // Clock, timeout and shared tasks
  // ***************************************************************
  always #4 core_clk_i = ~core_clk_i;

  // Hang guard
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      n_fail++;
      conclude();
    end
  end

  task automatic check_val(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("checks=%0d mismatches=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Request held until the taking edge; back to back when called again
  task automatic load_word(input logic [1:0] idx, input logic [23:0] data);
    @(negedge core_clk_i);
    load_valid_i = 1'b1;
    load_idx_i = idx;
    load_data_i = data;
    @(posedge core_clk_i);
  endtask

  task automatic rd_chk(input logic [1:0] idx, input logic [23:0] exp);
    @(negedge core_clk_i);
    rd_idx_i = idx;
    #1;
    `CHECK(rd_data_o, exp);
  endtask

  task automatic do_reset();
    @(negedge core_clk_i);
    rstn_i = 1'b0;
    repeat (2) @(negedge core_clk_i);
    rstn_i = 1'b1;
  endtask

  // ***************************************************************
  // Scenario: reset view, late load, run-state dependent outputs
  // ***************************************************************
  task automatic hold_scenario();
    @(negedge core_clk_i);
    rstn_i = 1'b0;
    repeat (2) @(negedge core_clk_i);
    for (int j = 0; j < 4; j++) rd_chk(2'(j), 24'hffffff);
    `CHECK({load_ready_o, load_done_o}, 2'b10);
    rstn_i = 1'b1;
    load_word(2'h0, 24'h000010);
    load_word(2'h1, 24'h002010);
    load_word(2'h2, 24'h001880);
    load_word(2'h0, 24'h00000f);
    @(negedge core_clk_i);
    load_valid_i = 1'b0;
    rd_chk(2'h0, 24'hff0010);
    rd_chk(2'h1, 24'hff2010);
    for (int j = 0; j < 8; j++) begin
      @(negedge core_clk_i);
      sleep_i = j[0];
      sys_clk_is_low_power_rc_osc_i = j[1];
      wdog_windowed_i = j[2];
      #1;
      `CHECK(wdog_cfg_o.clk_src, (j == 4) ? 2'h2 : 2'h3);
    end
    for (int j = 1; j >= 0; j--) begin
      @(negedge core_clk_i);
      deep_sleep_i = j[0];
      #1;
      `CHECK(brownout_active_o, !j[0]);
    end
    @(negedge core_clk_i);
    {sleep_i, sys_clk_is_low_power_rc_osc_i, wdog_windowed_i} = 3'b001;
  endtask

  // ***************************************************************
  // Scenario: reload sixteen word sets, decode every field code, 16 of the 128 boundary page codes
  // ***************************************************************
  task automatic sweep();
    logic [3:0] k;
    logic [6:0] pg;
    logic [23:0] w1, w2, w3;
    for (int i = 0; i < 16; i++) begin
      k = 4'(i);
      pg = {k, k[2:0]};
      w1 = {8'h5a, 11'h000, k[1], k};
      w2 = {8'h00, k[0], k[1], k[2], k[3], k[0] ^ k[3], k[2:0], k[1:0], k[3], k[3], k[0],
            1'b0, k[1:0]};
      w3 = {8'h00, k, 1'b1, k[1:0], k[2], 1'b1, pg};
      do_reset();
      load_word(2'h2, w3);
      load_word(2'h3, 24'h000000);
      load_word(2'h0, ~w1);
      load_word(2'h0, w1);
      #1;
      `CHECK(load_done_o, 1'b0);
      load_word(2'h1, w2);
      @(negedge core_clk_i);
      load_valid_i = 1'b0;
      `CHECK({load_ready_o, load_done_o}, 2'b01);
      rd_chk(2'h0, {8'hff, w1[15:0]});
      rd_chk(2'h2, {8'hff, w3[15:0]});
      rd_chk(2'h1, {8'hff, w2[15:0]});
      `CHECK(wdog_cfg_o.prescale_log2, k[1] ? 4'h7 : 4'h5);
      `CHECK(wdog_cfg_o.postscale_log2, k);
      `CHECK(clock_cfg_o.two_speed_en, k[0]);
      `CHECK(misc_cfg_o.battery_brownout_en, k[1]);
      `CHECK(wdog_cfg_o.clk_src, !k[2] ? 2'h3 : ({k[3], k[0]} == 2'h2 ? 2'h2 : {k[3], k[0]}));
      `CHECK({misc_cfg_o.cmp_dac_ref_alt_loc, misc_cfg_o.conv_ref_alt_loc}, {k[3], k[0] ^ k[3]});
      `CHECK(clock_cfg_o.startup, k[2:0]);
      `CHECK({clock_cfg_o.switch_en, clock_cfg_o.monitor_en}, {!k[1], k[1:0] == 2'h0});
      `CHECK(clock_cfg_o.clock_out_en, k[3] && (k[1:0] == 2'h3 || k[1:0] == 2'h0));
      `CHECK(clock_cfg_o.primary, k[1:0]);
      `CHECK(protect_cfg_o.seg_lo_addr, k[3] ? {pg, 9'h000} : 16'h0000);
      if (k[3]) `CHECK(protect_cfg_o.seg_hi_addr, 24'(PAGES * 512 - 1));
      else `CHECK(protect_cfg_o.seg_hi_addr, {pg, 9'h1ff});
      `CHECK(protect_cfg_o.cfg_page_prot, (!k[1] && !k[2]) || k[3] || pg == 7'(PAGES - 1));
      `CHECK(protect_cfg_o.seg_enable, !k[1]);
      `CHECK(misc_cfg_o.brownout_en, k[0]);
      `CHECK(wdog_cfg_o.window, k[1:0]);
      `CHECK(clock_cfg_o.secondary_osc_crystal, k[2]);
    end
  endtask

  // ***************************************************************
  // Main sequence
  // ***************************************************************
  initial begin
    {core_clk_i, rstn_i, load_valid_i, sleep_i, deep_sleep_i, sys_clk_is_low_power_rc_osc_i} = '0;
    {load_idx_i, rd_idx_i, load_data_i} = '0;
    wdog_windowed_i = 1'b1;
    {n_fail, check_count, cycles} = '0;
    repeat (20) @(negedge core_clk_i);
    rstn_i = 1'b1;
    hold_scenario();
    sweep();
    conclude();
  end
endmodule // config_word_decode_test

// *** rtl/cfg_pkg.sv ***
package cfg_pkg;

  // ***************************************************************
  // Word geometry
  // ***************************************************************
  localparam int unsigned WORD_W        = 24;
  localparam int unsigned NUM_WORDS     = 3;
  localparam int unsigned ADDR_W        = 2;
  localparam int unsigned PAGE_W        = 7;
  localparam int unsigned PAGE_WORDS    = 512;
  localparam int unsigned FLASH_ADDR_W  = 24;
  localparam logic [7:0]  UNIMPL_ONES   = 8'hff;
  localparam logic [23:0] ERASED_WORD   = 24'hffffff;

  // Word indices on the load and read ports
  localparam logic [1:0]  IDX_WORD_ONE   = 2'h0;
  localparam logic [1:0]  IDX_WORD_TWO   = 2'h1;
  localparam logic [1:0]  IDX_WORD_THREE = 2'h2;

  // ***************************************************************
  // Field positions, word one
  // ***************************************************************
  localparam int unsigned W1_PRESCALE_BIT = 4;
  localparam int unsigned W1_POSTSCALE_LO = 0;

  // ***************************************************************
  // Field positions, word two
  // ***************************************************************
  localparam int unsigned W2_TWO_SPEED_BIT  = 15;
  localparam int unsigned W2_BATT_BOR_BIT   = 14;
  localparam int unsigned W2_WDOG_MUX_BIT   = 13;
  localparam int unsigned W2_CMP_REF_BIT    = 12;
  localparam int unsigned W2_CONV_REF_BIT   = 11;
  localparam int unsigned W2_STARTUP_LO     = 8;
  localparam int unsigned W2_CLK_SW_LO      = 6;
  localparam int unsigned W2_OSC_OUT_BIT    = 5;
  localparam int unsigned W2_WDOG_CLK_LO    = 3;
  localparam int unsigned W2_PRI_OSC_LO     = 0;

  // ***************************************************************
  // Field positions, word three
  // ***************************************************************
  localparam int unsigned W3_END_PAGE_BIT   = 15;
  localparam int unsigned W3_CFG_PROT_BIT   = 14;
  localparam int unsigned W3_SEG_DIS_BIT    = 13;
  localparam int unsigned W3_BOR_BIT        = 12;
  localparam int unsigned W3_WIN_LO         = 9;
  localparam int unsigned W3_SECONDARY_OSC_BIT       = 8;
  localparam int unsigned W3_BOUNDARY_LO    = 0;

  // ***************************************************************
  // Decoded enumerations
  // ***************************************************************
  typedef enum logic [2:0] {
    OSC_FAST_RC, OSC_FAST_RC_DIV_PLL, OSC_PRIMARY, OSC_PRIMARY_PLL,
    OSC_SECONDARY, OSC_LOW_POWER_RC, OSC_RESERVED, OSC_FAST_RC_DIV
  } startup_osc_t;

  typedef enum logic [1:0] {
    PRI_EXTERNAL_CLOCK, PRI_STANDARD_CRYSTAL, PRI_HIGH_SPEED_CRYSTAL, PRI_DISABLED
  } primary_osc_t;

  typedef enum logic [1:0] {
    WCLK_SYSTEM, WCLK_SECONDARY, WCLK_FAST_RC_31K, WCLK_LOW_POWER_RC
  } wdog_clk_src_t;

  typedef enum logic [1:0] {
    WIN_75_PCT, WIN_50_PCT, WIN_37_5_PCT, WIN_25_PCT
  } wdog_window_t;

  // Prescaler shift amounts: 1:32 and 1:128
  localparam logic [3:0] PRESCALE_LOG2_LO = 4'h5;
  localparam logic [3:0] PRESCALE_LOG2_HI = 4'h7;

  // ***************************************************************
  // Carriers
  // ***************************************************************
  typedef struct packed {
    logic [3:0]    prescale_log2;
    logic [3:0]    postscale_log2;
    wdog_clk_src_t clk_src;
    wdog_window_t  window;
  } wdog_cfg_t;

  typedef struct packed {
    startup_osc_t  startup;
    primary_osc_t  primary;
    logic          two_speed_en;
    logic          switch_en;
    logic          monitor_en;
    logic          clock_out_en;
    logic          secondary_osc_crystal;
  } clock_cfg_t;

  typedef struct packed {
    logic          seg_enable;
    logic [FLASH_ADDR_W-1:0] seg_lo_addr;
    logic [FLASH_ADDR_W-1:0] seg_hi_addr;
    logic          cfg_page_prot;
  } protect_cfg_t;

  typedef struct packed {
    logic          brownout_en;
    logic          battery_brownout_en;
    logic          cmp_dac_ref_alt_loc;
    logic          conv_ref_alt_loc;
  } misc_cfg_t;

endpackage

// *** rtl/cfg_word_reg.sv ***
// ***************************************************************
// One configuration word: captured on every load, held until the next load or reset
// ***************************************************************
module cfg_word_reg #(
  parameter int unsigned WIDTH = 16
) (
  // Clock and reset
  input  wire logic             core_clk_i,
  input  wire logic             rstn_i,
  // Load
  input  wire logic             load_i,
  input  wire logic [WIDTH-1:0] data_i,
  // Held value
  output logic      [WIDTH-1:0] word_o
);

  typedef struct packed {
    logic [WIDTH-1:0] word;
  } state_t;

  state_t state_reg;
  state_t state_next;

  // Next state: capture only on load
  always_comb begin
    state_next = state_reg;
    if (load_i) begin
      state_next.word = data_i;
    end
  end

  // Erased value (all ones) until loaded
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg <= '{word: '1};
    end else begin
      state_reg <= state_next;
    end
  end

  assign word_o = state_reg.word;

endmodule // cfg_word_reg

// *** rtl/config_word_decode.sv ***
// Function
// - Prescale bit: 1 gives 1:128, 0 gives 1:32
// - Postscaler ratio is two to field value
// - Bits 23..16 of each word read ones
// - Switchover bit enables two-speed start-up
// - Mux bit 0 forces low-power RC watchdog clock
// - Mux on: 2-bit field picks watchdog clock
// - Code 10: fast RC when windowed, awake and system clock not low-power RC, else LOW_POWER_RC_OSC
// - Reference location bits pick alternate pins
// - Decode 3-bit start-up oscillator selection
// - Clock switching and monitor field decode
// - Clock-out pin only in modes 11/00
// - Decode 2-bit primary oscillator mode
// - End-page bit picks top or bottom segment
// - Config-page bit 0 protects last page while the disable bit is 0
// - Disable bit turns segment protection off
// - Word three bit 12 enables brown-out reset
// - Window field selects 25 to 75 percent
// - Bit 8 picks crystal or digital clock
// - Config page always protected in listed cases
// - Reload all words on every reset
// - Programmed bits read zero, erased read one
// - Boundary pages are 512 instruction words
module config_word_decode #(
  parameter int unsigned FLASH_PAGES = 128
) (
  // Clock and reset
  input  wire logic                          core_clk_i,
  input  wire logic                          rstn_i,
  // Word load from flash after reset
  input  wire logic                          load_valid_i,
  input  wire logic [1:0]                    load_idx_i,
  input  wire logic [cfg_pkg::WORD_W-1:0]    load_data_i,
  output logic                               load_ready_o,
  output logic                               load_done_o,
  // Configuration read port
  input  wire logic [1:0]                    rd_idx_i,
  output logic [cfg_pkg::WORD_W-1:0]         rd_data_o,
  // Run-time device state
  input  wire logic                          sleep_i,
  input  wire logic                          deep_sleep_i,
  input  wire logic                          sys_clk_is_low_power_rc_osc_i,
  input  wire logic                          wdog_windowed_i,
  // Decoded settings
  output cfg_pkg::wdog_cfg_t                 wdog_cfg_o,
  output cfg_pkg::clock_cfg_t                clock_cfg_o,
  output cfg_pkg::protect_cfg_t              protect_cfg_o,
  output cfg_pkg::misc_cfg_t                 misc_cfg_o,
  output logic                               brownout_active_o
);

  // ***************************************************************
  // Elaboration checks
  // ***************************************************************
  localparam int unsigned MAX_PAGES = 1 << cfg_pkg::PAGE_W;

  initial begin
    if (FLASH_PAGES < 2 || FLASH_PAGES > MAX_PAGES) begin
      $error("FLASH_PAGES out of range");
    end
  end

  localparam logic [cfg_pkg::PAGE_W-1:0] LAST_PAGE =
    cfg_pkg::PAGE_W'(FLASH_PAGES - 1);
  localparam int unsigned PAGE_SHIFT = $clog2(cfg_pkg::PAGE_WORDS);

  // ***************************************************************
  // Load sequencing
  // ***************************************************************
  typedef enum logic [1:0] {ST_LOAD, ST_HOLD, ST_ERR} load_state_t;

  typedef struct packed {
    load_state_t                     state;
    logic [cfg_pkg::NUM_WORDS-1:0]   seen;
  } state_t;

  state_t state_reg;
  state_t state_next;

  logic [cfg_pkg::NUM_WORDS-1:0] load_en;
  logic [cfg_pkg::WORD_W-1:0]    word [cfg_pkg::NUM_WORDS];

  // Next state: collect words, last load of an index wins, until all three seen, then freeze
  always_comb begin
    state_next = state_reg;
    load_en    = '0;
    case (state_reg.state)
      ST_LOAD: begin
        if (load_valid_i && (load_idx_i < 2'(cfg_pkg::NUM_WORDS))) begin
          load_en[load_idx_i]        = 1'b1;
          state_next.seen[load_idx_i] = 1'b1;
        end
        if (&state_next.seen) begin
          state_next.state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        state_next = state_reg;
      end
      default: begin
        state_next.state = ST_HOLD;
      end
    endcase
  end

  // State register: every reset returns to loading
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg <= '{state: ST_LOAD, seen: '0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign load_ready_o = (state_reg.state == ST_LOAD);
  assign load_done_o  = (state_reg.state == ST_HOLD);

  // ***************************************************************
  // Word storage, lower 16 bits only
  // ***************************************************************
  for (genvar g = 0; g < cfg_pkg::NUM_WORDS; g++) begin : g_word
    logic [15:0] held;
    cfg_word_reg #(
      .WIDTH (16)
    ) u_word (
      .core_clk_i (core_clk_i),
      .rstn_i     (rstn_i),
      .load_i     (load_en[g]),
      .data_i     (load_data_i[15:0]),
      .word_o     (held)
    );
    // Erased bits read one, programmed read zero
    assign word[g] = {cfg_pkg::UNIMPL_ONES, held};
  end

  // Read mux; unknown index reads as erased
  always_comb begin
    rd_data_o = cfg_pkg::ERASED_WORD;
    if (rd_idx_i < 2'(cfg_pkg::NUM_WORDS)) begin
      rd_data_o = word[rd_idx_i];
    end
  end

  // ***************************************************************
  // Field extraction
  // ***************************************************************
  logic [cfg_pkg::WORD_W-1:0] w1;
  logic [cfg_pkg::WORD_W-1:0] w2;
  logic [cfg_pkg::WORD_W-1:0] w3;

  assign w1 = word[cfg_pkg::IDX_WORD_ONE];
  assign w2 = word[cfg_pkg::IDX_WORD_TWO];
  assign w3 = word[cfg_pkg::IDX_WORD_THREE];

  logic                       wdog_prescale_sel;
  logic [3:0]                 wdog_postscale_sel;
  logic                       two_speed_startup_en;
  logic                       battery_brownout_en;
  logic                       wdog_clock_mux_en;
  logic                       cmp_dac_ref_alt_loc;
  logic                       conv_ref_alt_loc;
  logic [2:0]                 startup_osc_sel;
  logic [1:0]                 clock_switch_monitor_cfg;
  logic                       osc_out_pin_func;
  logic [1:0]                 wdog_clock_sel;
  logic [1:0]                 primary_osc_mode;
  logic                       protect_end_page_sel;
  logic                       config_page_protect;
  logic                       segment_protect_disable;
  logic                       brownout_reset_en;
  logic [1:0]                 wdog_window_width;
  logic                       secondary_osc_mode_sel;
  logic [cfg_pkg::PAGE_W-1:0] protect_boundary_page;

  // Word one tail
  assign wdog_prescale_sel  = w1[cfg_pkg::W1_PRESCALE_BIT];
  assign wdog_postscale_sel = w1[cfg_pkg::W1_POSTSCALE_LO +: 4];

  // Word two fields
  assign two_speed_startup_en     = w2[cfg_pkg::W2_TWO_SPEED_BIT];
  assign battery_brownout_en      = w2[cfg_pkg::W2_BATT_BOR_BIT];
  assign wdog_clock_mux_en        = w2[cfg_pkg::W2_WDOG_MUX_BIT];
  assign cmp_dac_ref_alt_loc      = w2[cfg_pkg::W2_CMP_REF_BIT];
  assign conv_ref_alt_loc         = w2[cfg_pkg::W2_CONV_REF_BIT];
  assign startup_osc_sel          = w2[cfg_pkg::W2_STARTUP_LO +: 3];
  assign clock_switch_monitor_cfg = w2[cfg_pkg::W2_CLK_SW_LO +: 2];
  assign osc_out_pin_func         = w2[cfg_pkg::W2_OSC_OUT_BIT];
  assign wdog_clock_sel           = w2[cfg_pkg::W2_WDOG_CLK_LO +: 2];
  assign primary_osc_mode         = w2[cfg_pkg::W2_PRI_OSC_LO +: 2];

  // Word three fields
  assign protect_end_page_sel    = w3[cfg_pkg::W3_END_PAGE_BIT];
  assign config_page_protect     = w3[cfg_pkg::W3_CFG_PROT_BIT];
  assign segment_protect_disable = w3[cfg_pkg::W3_SEG_DIS_BIT];
  assign brownout_reset_en       = w3[cfg_pkg::W3_BOR_BIT];
  assign wdog_window_width       = w3[cfg_pkg::W3_WIN_LO +: 2];
  assign secondary_osc_mode_sel  = w3[cfg_pkg::W3_SECONDARY_OSC_BIT];
  assign protect_boundary_page   = w3[cfg_pkg::W3_BOUNDARY_LO +: cfg_pkg::PAGE_W];

  // ***************************************************************
  // Watchdog decode
  // ***************************************************************
  cfg_pkg::wdog_clk_src_t wdog_clk_src;

  // Clock source with sleep and window dependence
  always_comb begin
    wdog_clk_src = cfg_pkg::WCLK_LOW_POWER_RC;
    if (wdog_clock_mux_en) begin
      case (wdog_clock_sel)
        2'h3: wdog_clk_src = cfg_pkg::WCLK_LOW_POWER_RC;
        2'h2: begin
          if (wdog_windowed_i && !sys_clk_is_low_power_rc_osc_i && !sleep_i) begin
            wdog_clk_src = cfg_pkg::WCLK_FAST_RC_31K;
          end else begin
            wdog_clk_src = cfg_pkg::WCLK_LOW_POWER_RC;
          end
        end
        2'h1: wdog_clk_src = cfg_pkg::WCLK_SECONDARY;
        2'h0: begin
          wdog_clk_src = sleep_i ? cfg_pkg::WCLK_LOW_POWER_RC
                                 : cfg_pkg::WCLK_SYSTEM;
        end
        default: wdog_clk_src = cfg_pkg::WCLK_LOW_POWER_RC;
      endcase
    end
  end

  // Ratios as power-of-two exponents
  always_comb begin
    wdog_cfg_o.prescale_log2  = wdog_prescale_sel ? cfg_pkg::PRESCALE_LOG2_HI
                                                  : cfg_pkg::PRESCALE_LOG2_LO;
    wdog_cfg_o.postscale_log2 = wdog_postscale_sel;
    wdog_cfg_o.clk_src        = wdog_clk_src;
    wdog_cfg_o.window         = cfg_pkg::wdog_window_t'(wdog_window_width);
  end

  // ***************************************************************
  // Clock decode
  // ***************************************************************
  always_comb begin
    clock_cfg_o.startup      = cfg_pkg::startup_osc_t'(startup_osc_sel);
    clock_cfg_o.primary      = cfg_pkg::primary_osc_t'(primary_osc_mode);
    clock_cfg_o.two_speed_en = two_speed_startup_en;
    clock_cfg_o.switch_en    = !clock_switch_monitor_cfg[1];
    clock_cfg_o.monitor_en   = (clock_switch_monitor_cfg == 2'h0);
    clock_cfg_o.clock_out_en = osc_out_pin_func &&
                               ((primary_osc_mode == 2'h3) ||
                                (primary_osc_mode == 2'h0));
    clock_cfg_o.secondary_osc_crystal = secondary_osc_mode_sel;
  end

  // ***************************************************************
  // Write protection decode
  // ***************************************************************
  logic [cfg_pkg::FLASH_ADDR_W-1:0] boundary_addr;
  logic [cfg_pkg::FLASH_ADDR_W-1:0] last_page_addr;
  logic                             boundary_is_cfg;

  // Page number to instruction-word address
  assign boundary_addr  = cfg_pkg::FLASH_ADDR_W'(protect_boundary_page) << PAGE_SHIFT;
  assign last_page_addr = cfg_pkg::FLASH_ADDR_W'(LAST_PAGE) << PAGE_SHIFT;
  assign boundary_is_cfg = (protect_boundary_page == LAST_PAGE);

  always_comb begin
    protect_cfg_o.seg_enable = !segment_protect_disable;
    if (protect_end_page_sel) begin
      protect_cfg_o.seg_lo_addr = boundary_addr;
      protect_cfg_o.seg_hi_addr = last_page_addr | cfg_pkg::FLASH_ADDR_W'(cfg_pkg::PAGE_WORDS - 1);
    end else begin
      protect_cfg_o.seg_lo_addr = '0;
      protect_cfg_o.seg_hi_addr = boundary_addr | cfg_pkg::FLASH_ADDR_W'(cfg_pkg::PAGE_WORDS - 1);
    end
    protect_cfg_o.cfg_page_prot = (!config_page_protect && !segment_protect_disable)
                                  || protect_end_page_sel || boundary_is_cfg;
  end

  // ***************************************************************
  // Brown-out and reference placement
  // ***************************************************************
  always_comb begin
    misc_cfg_o.brownout_en         = brownout_reset_en;
    misc_cfg_o.battery_brownout_en = battery_brownout_en;
    misc_cfg_o.cmp_dac_ref_alt_loc = cmp_dac_ref_alt_loc;
    misc_cfg_o.conv_ref_alt_loc    = conv_ref_alt_loc;
  end

  // Brown-out reset armed outside deep sleep
  assign brownout_active_o = brownout_reset_en && !deep_sleep_i;

endmodule // config_word_decode
